// ==== pkg/drac_pkg.sv ====
// constants and types of the two-channel transfer request / acknowledge control
// assumes one bus clock (hclk) and a bus cycle controller that sequences every cycle
// How it works
// (RL1) peripheral requests need falling-edge detect and cycle-steal; otherwise rejected here
// (RL2) external burst requests need edge detection; level plus burst is rejected
// (RL3) 16-byte units need edge detection; level plus 16-byte is rejected
// (RL4) level requests: byte/word/long cycle-steal only; edge: all sizes, both modes
// (RL5) rising and falling polarity allow the same mode combinations
// (RL6) a serial port requesting must itself be transfer source or destination; not checked here
// (RL7) transfer unit must suit the peripheral register that is accessed; not checked here, any size but 16-byte is accepted
// (RL8) internal-to-external uses write-phase acknowledge, reverse uses read-phase
// (RL9) higher channel request during lower burst is served at the next unit boundary
// (RL10) burst higher channel runs to its end before lower burst resumes
// (RL11) cycle-steal higher channel alternates unit by unit with lower burst channel
// (RL12) state counts of every transfer cycle come from the bus cycle controller
// (RL13) acknowledge follows the address of the cycle chosen by ack phase select
// (RL14) ordinary space: ack with address, dropped in the address's last half cycle
// (RL15) split accesses give one acknowledge per address phase
// (RL16) synchronous dram: acknowledge spans exactly the address output
// (RL17) auto-precharge read ack spans row, command, wait and read address
// (RL18) single sdram read holds acknowledge until the following write address
// (RL19) 16-byte units only with auto or edge external requests
// (RL20) auto-precharge write ack spans row and column address
// (RL21) bank-active read ack spans command..address, plus precharge/row on row change
// (RL22) request detected then first transfer cycle no earlier than four cycles later
// (RL23) burst keeps the bus until the transfer count ends
// (RL24) ack phase select 0 means read cycle, 1 means write cycle
// (RL25) illegal combinations are flagged and the channel never starts
package drac_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CH0_CTRL = 8'h00;
  localparam logic [7:0] OFS_CH0_CNT = 8'h04;
  localparam logic [7:0] OFS_CH1_CTRL = 8'h08;
  localparam logic [7:0] OFS_CH1_CNT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // control register fields
  localparam int CTRL_W = 11;
  localparam int B_EN = 0;
  localparam int B_SRC = 1; // two bits
  localparam int B_DETSEL = 3; // 1 edge, 0 level
  localparam int B_DETLVL = 4; // 1 high/rising, 0 low/falling
  localparam int B_BURST = 5;
  localparam int B_SINGLE = 6;
  localparam int B_SIZE = 7; // two bits
  localparam int B_ACKPH = 9;
  localparam int B_SDRAM = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // request sources and unit sizes
  localparam logic [1:0] SRC_AUTO = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_PERI = 2'h2;
  localparam logic [1:0] SIZE_16B = 2'h3;
  // cycles from request detection to the first transfer cycle
  localparam logic [2:0] REQ_LAT_CYC = 3'h4;
  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} drac_st_t;
  typedef logic [CTRL_W-1:0] drac_ctrl_t;
endpackage : drac_pkg

// ==== src/drac_ctrl.sv ====
// request detection, channel arbitration and acknowledge timing, AHB-Lite registers
// assumes the bus cycle controller owns cycle states and flags address phases
`timescale 1ns/100ps
module drac_ctrl
  import drac_pkg::*;
(
  input wire logic hclk, // bus clock, 10 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write request
  input wire logic [2:0] hsize, // always word
  input wire logic hready, // bus ready
  input wire logic [31:0] hwdata, // write data
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic [1:0] transfer_req_in, // request pins, async
  input wire logic [1:0] periph_req_in, // peripheral request pulses
  input wire logic bcc_addr_valid, // dma address on the bus
  input wire logic bcc_addr_ending, // last cycle of that address
  input wire logic bcc_read_cyc, // 1 read cycle, 0 write cycle
  input wire logic bcc_sdram_span, // sdram span of the cycle
  input wire logic bcc_single_read, // sdram single read in progress
  input wire logic bcc_unit_done, // one transfer unit finished
  output logic dma_cyc_req, // ask for transfer cycles
  output logic dma_cyc_ch, // channel that owns them
  output logic dma_bus_hold, // keep bus from the cpu
  output logic [1:0] transfer_ack_out // acknowledge, active high
);

  typedef struct packed {
    drac_ctrl_t [1:0] ctrl;
    logic [1:0][15:0] count;
    logic [1:0][2:0] sync;
    logic [1:0] filt;
    logic [1:0] fprev;
    logic [1:0] pend;
    logic [1:0] arm;
    logic [1:0] burst_act;
    logic [1:0] done;
    logic [1:0][2:0] lat;
    logic [1:0] ack;
    logic sd_hold;
    drac_st_t state;
    logic owner;
    logic last_cs0;
    logic rd_pend;
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic cyc_req;
    logic hold;
  } drac_state_t;

  drac_state_t s;
  drac_state_t next_s;

  // legal combination check of one control word
  function automatic logic legal(input drac_ctrl_t c);
    logic ok;
    ok = 1'b1;
    // external level detect plus burst or 16-byte units is never started
    if (c[B_SRC +: 2] == SRC_EXT && !c[B_DETSEL])
      ok = !c[B_BURST] && c[B_SIZE +: 2] != SIZE_16B; // [RL2] [RL3] [RL4]
    // peripheral source: falling edge, cycle-steal, no 16-byte
    if (c[B_SRC +: 2] == SRC_PERI)
      ok = c[B_DETSEL] && !c[B_DETLVL] && !c[B_BURST]
        && c[B_SIZE +: 2] != SIZE_16B; // [RL1] [RL19]
    if (c[B_SRC +: 2] == 2'h3)
      ok = 1'b0;
    // polarity bit is not looked at for external sources [RL5]
    return ok;
  endfunction : legal

  logic [1:0] run_ok;
  logic [1:0] hit;
  logic [1:0] ready;
  logic [1:0] err;
  logic pick;
  logic pm;
  logic a;
  logic [31:0] rd_mux;

  // next state of the whole block
  always_comb
  begin
    next_s = s;
    run_ok = '0;
    hit = '0;
    ready = '0;
    err = '0;
    pick = 1'b0;
    pm = 1'b0;
    a = 1'b0;
    rd_mux = 32'h0000_0000;

    // bus address phase capture
    if (hready)
    begin
      next_s.wr_pend = 1'b0;
      if (hsel && htrans[1])
      begin
        next_s.addr = haddr;
        next_s.wr_pend = hwrite;
        next_s.rd_pend = !hwrite;
        next_s.hreadyout = hwrite; // one wait state so reads see fresh state
      end
    end

    // register writes in the data phase; hardware sets below win
    if (s.wr_pend)
    begin
      case (s.addr)
        OFS_CH0_CTRL:
        begin
          next_s.ctrl[0] = hwdata[CTRL_W-1:0];
          next_s.done[0] = 1'b0;
        end
        OFS_CH1_CTRL:
        begin
          next_s.ctrl[1] = hwdata[CTRL_W-1:0];
          next_s.done[1] = 1'b0;
        end
        OFS_CH0_CNT: next_s.count[0] = hwdata[15:0];
        OFS_CH1_CNT: next_s.count[1] = hwdata[15:0];
        default: next_s.addr = s.addr; // unmapped writes are dropped
      endcase
    end

    // per-channel request detection
    for (int i = 0; i < 2; i++)
    begin
      // three-stage synchroniser, change taken when stages two and three agree
      next_s.sync[i] = {s.sync[i][1:0], transfer_req_in[i]};
      if (s.sync[i][1] == s.sync[i][2])
        next_s.filt[i] = s.sync[i][2];
      next_s.fprev[i] = s.filt[i];
      err[i] = s.ctrl[i][B_EN] && !legal(s.ctrl[i]);
      run_ok[i] = s.ctrl[i][B_EN] && !err[i] && s.count[i] != 16'h0000; // [RL25]
      case (s.ctrl[i][B_SRC +: 2])
        SRC_AUTO: hit[i] = 1'b1;
        SRC_EXT:
          if (s.ctrl[i][B_DETSEL])
            hit[i] = s.filt[i] == s.ctrl[i][B_DETLVL]
              && s.fprev[i] != s.ctrl[i][B_DETLVL]; // [RL5]
          else
            hit[i] = s.filt[i] == s.ctrl[i][B_DETLVL]; // [RL4]
        SRC_PERI: hit[i] = periph_req_in[i];
        default: hit[i] = 1'b0;
      endcase
      // accepted request stays pending until served or the channel stops running; detection waits for the ack
      if (run_ok[i] && !s.pend[i] && s.arm[i] && hit[i])
      begin
        next_s.pend[i] = 1'b1;
        next_s.arm[i] = 1'b0;
        next_s.lat[i] = 3'h1;
        next_s.burst_act[i] = s.ctrl[i][B_BURST];
      end
      // latency count before the first cycle
      if (s.pend[i] && s.lat[i] != REQ_LAT_CYC)
        next_s.lat[i] = s.lat[i] + 3'h1; // [RL22]
      ready[i] = s.pend[i] && s.lat[i] == REQ_LAT_CYC && run_ok[i];
      if (!run_ok[i])
      begin
        next_s.pend[i] = 1'b0;
        next_s.burst_act[i] = 1'b0;
      end
      if (s.ack[i])
        next_s.arm[i] = 1'b1;
    end

    // arbitration: channel 0 first, alternation when it steals from a burst
    if (ready[1] && s.burst_act[1] && s.last_cs0)
      pick = 1'b1; // [RL11]
    else if (ready[0])
      pick = 1'b0; // [RL9] [RL10]
    else
      pick = 1'b1;

    // transfer sequencing; cycle states themselves belong to the controller
    next_s.ack = '0;
    case (s.state)
      ST_IDLE:
        if (|ready)
        begin
          next_s.owner = pick;
          next_s.cyc_req = 1'b1; // [RL12]
          next_s.state = ST_RUN;
        end
      ST_RUN:
      begin
        // phase select 0 acks the read cycle, 1 the write cycle
        pm = bcc_read_cyc != s.ctrl[s.owner][B_ACKPH]; // [RL24] [RL13]
        if (s.ctrl[s.owner][B_SDRAM])
        begin
          // controller span covers row/cmd/wait/address per memory mode
          a = (bcc_sdram_span && pm) || s.sd_hold; // [RL16] [RL17] [RL20] [RL21]
          if (bcc_sdram_span && pm && bcc_read_cyc && bcc_single_read)
            next_s.sd_hold = 1'b1; // [RL18]
          if (bcc_addr_valid && !bcc_read_cyc)
          begin
            next_s.sd_hold = 1'b0;
            a = bcc_sdram_span && pm;
          end
        end
        else
          // each split address phase gets its own pulse
          a = bcc_addr_valid && pm && !bcc_addr_ending; // [RL14] [RL15]
        next_s.ack[s.owner] = a;
        if (bcc_unit_done)
        begin
          next_s.cyc_req = 1'b0;
          next_s.sd_hold = 1'b0;
          next_s.ack = '0;
          next_s.state = ST_IDLE;
          next_s.arm[s.owner] = 1'b1;
          next_s.last_cs0 = !s.owner && !s.burst_act[0];
          next_s.count[s.owner] = s.count[s.owner] - 16'h0001;
          // burst holds its request until the count ends
          if (!s.burst_act[s.owner] || s.count[s.owner] == 16'h0001)
          begin
            next_s.pend[s.owner] = 1'b0;
            next_s.burst_act[s.owner] = 1'b0; // [RL23]
          end
          if (s.count[s.owner] == 16'h0001)
            next_s.done[s.owner] = 1'b1;
        end
      end
      default: next_s.state = ST_IDLE;
    endcase
    // cpu is kept off the bus while any burst is alive
    next_s.hold = |next_s.burst_act; // [RL23]

    // read data mux for the wait cycle
    case (s.addr)
      OFS_CH0_CTRL: rd_mux[CTRL_W-1:0] = s.ctrl[0];
      OFS_CH1_CTRL: rd_mux[CTRL_W-1:0] = s.ctrl[1];
      OFS_CH0_CNT: rd_mux[15:0] = s.count[0];
      OFS_CH1_CNT: rd_mux[15:0] = s.count[1];
      OFS_STATUS: rd_mux[8:0] = {s.state, s.burst_act, s.done, err, s.pend};
      default: rd_mux = 32'h0000_0000; // unmapped reads as zero
    endcase
    if (s.rd_pend)
    begin
      next_s.hrdata = rd_mux;
      next_s.hreadyout = 1'b1;
      next_s.rd_pend = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.ctrl <= {CTRL_RST, CTRL_RST};
      s.count <= {CNT_RST, CNT_RST};
      s.arm <= 2'h3;
      s.hreadyout <= 1'b1;
      s.state <= ST_IDLE;
    end
    else
      s <= next_s;
  end

  // outputs straight from the state register, hresp tied to okay
  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign dma_cyc_req = s.cyc_req;
  assign dma_cyc_ch = s.owner;
  assign dma_bus_hold = s.hold;
  assign transfer_ack_out = s.ack;

endmodule : drac_ctrl

// ==== verification/drac_ctrl_asserts.sv ====
// port checks for the transfer request / acknowledge control
// assumes one clock hclk and async active-low hresetn
`timescale 1ns/100ps
module drac_ctrl_checker (
  input logic hclk, // bus clock
  input logic hresetn, // reset, active low
  input logic hsel, // slave select
  input logic [1:0] htrans, // transfer type
  input logic hwrite, // write request
  input logic hready, // bus ready
  input logic hreadyout, // slave ready
  input logic hresp, // response
  input logic bcc_addr_valid, // dma address on bus
  input logic bcc_addr_ending, // last address cycle
  input logic bcc_sdram_span, // sdram span
  input logic bcc_single_read, // sdram single read
  input logic bcc_unit_done, // unit finished
  input logic dma_cyc_req, // cycle request
  input logic dma_cyc_ch, // owning channel
  input logic [1:0] transfer_ack_out // acknowledges
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // bus side: one wait per read, none per write, always okay
  property p_rd; hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd: assert property (p_rd) else $error("read wait state wrong");
  property p_wr; hready && hsel && htrans[1] && hwrite |=> hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("write was stretched");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  // acknowledge only starts from a dma address or sdram span
  property p_ack_start; $rose(|transfer_ack_out) |-> $past(bcc_addr_valid | bcc_sdram_span); endproperty
  a_ack_start: assert property (p_ack_start) else $error("ack without address");
  // ordinary space is low in the cycle after the last address cycle
  property p_ack_end;
    bcc_addr_ending && !bcc_sdram_span && !bcc_single_read |=> transfer_ack_out == 2'h0;
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack held too long");
  property p_ack_ch; |transfer_ack_out |-> transfer_ack_out[$past(dma_cyc_ch)]; endproperty
  a_ack_ch: assert property (p_ack_ch) else $error("ack on wrong channel");
  property p_ack_one; $onehot0(transfer_ack_out); endproperty
  a_ack_one: assert property (p_ack_one) else $error("two acks at once");
  property p_release; bcc_unit_done |=> !dma_cyc_req; endproperty
  a_release: assert property (p_release) else $error("request kept after unit");
endmodule : drac_ctrl_checker

bind drac_ctrl drac_ctrl_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .bcc_addr_valid, .bcc_addr_ending, .bcc_sdram_span, .bcc_single_read,
  .bcc_unit_done, .dma_cyc_req, .dma_cyc_ch, .transfer_ack_out);

// ==== verification/drac_bcc_model.sv ====
// behavioural bus cycle controller with an ordinary memory behind it
// assumes a cycle request is held until the unit-done pulse is seen
`timescale 1ns/100ps
module drac_bcc_model (
  input logic hclk, // bus clock
  input logic hresetn, // reset, active low
  input logic dma_cyc_req, // cycle request
  output logic bcc_addr_valid, // dma address out
  output logic bcc_addr_ending, // last address cycle
  output logic bcc_read_cyc, // read cycle flag
  output logic bcc_unit_done // unit finished
);
  logic [2:0] st;
  // read address in 1-2, write address in 3-4, done in 5; states set here only
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      st <= 3'h0;
    else if (st == 3'h5)
      st <= 3'h0;
    else if (st != 3'h0 || dma_cyc_req)
      st <= st + 3'h1;
  // two separate address runs per unit, like a split access
  assign bcc_addr_valid = st != 3'h0 && st != 3'h5;
  assign bcc_addr_ending = st == 3'h2 || st == 3'h4;
  assign bcc_read_cyc = st < 3'h3;
  assign bcc_unit_done = st == 3'h5;
endmodule : drac_bcc_model

// ==== verification/tb_drac_ctrl.sv ====
// self-checking bench for the transfer request / acknowledge control
// assumes the bus cycle model stands in for memories and the cycle controller
`timescale 1ns/100ps
module tb_drac_ctrl;
  import drac_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [1:0] transfer_req_in = 2'h0, periph_req_in = 2'h0, transfer_ack_out;
  logic bcc_single_read = 1'b0, sd = 1'b0, bcc_sdram_span, am, last_ch, last_rd, last_req, last_ack;
  logic hready, hreadyout, hresp, bcc_addr_valid, bcc_addr_ending, bcc_read_cyc, bcc_unit_done;
  logic dma_cyc_req, dma_cyc_ch, dma_bus_hold;
  // no serial port as source and whole-register unit sizes only
  logic [10:0] cfg [10] = '{11'h023, 11'h183, 11'h01D, 11'h02D, 11'h007,
    11'h00D, 11'h1AB, 11'h1BB, 11'h003, 11'h043};
  logic [9:0] errs = 10'h01F; // first five settings are not allowed
  int n_fail = 0, n_compared = 0, lat, bad, nack, nhi, pair, n0;
  assign hready = hreadyout;
  // in sdram space the acknowledge span is the dma address itself
  assign bcc_sdram_span = sd && bcc_addr_valid;
  drac_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
    .hrdata, .hreadyout, .hresp, .transfer_req_in, .periph_req_in, .bcc_addr_valid,
    .bcc_addr_ending, .bcc_read_cyc, .bcc_sdram_span, .bcc_single_read, .bcc_unit_done,
    .dma_cyc_req, .dma_cyc_ch, .dma_bus_hold, .transfer_ack_out);
  drac_bcc_model u_bcc (.hclk, .hresetn, .dma_cyc_req, .bcc_addr_valid, .bcc_addr_ending,
    .bcc_read_cyc, .bcc_unit_done);
  always #50 hclk = ~hclk;
  // ack phase, ack starts and channel order seen at the ports
  always @(posedge hclk)
  begin
    if (transfer_ack_out != 2'h0 && last_rd !== ~am) bad++;
    if (transfer_ack_out != 2'h0 && !last_ack) nack++;
    if (transfer_ack_out != 2'h0) nhi++;
    if (dma_cyc_req && !last_req)
    begin
      if (!dma_cyc_ch && !last_ch) pair++;
      if (!dma_cyc_ch) n0++;
      last_ch <= dma_cyc_ch;
    end
    last_rd <= bcc_read_cyc;
    last_req <= dma_cyc_req;
    last_ack <= |transfer_ack_out;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  // polls status until bit b is set, bounded
  task automatic wait_st(input int b);
    rd = 32'h0;
    for (int i = 0; i < 100 && rd[b] !== 1'b1; i++) bus(1'b0, OFS_STATUS, 32'h0);
  endtask : wait_st
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    end_sim;
  end
  initial
  begin
    am = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, read-only status and unmapped place
    bus(1'b1, OFS_STATUS, 32'h1FF);
    bus(1'b1, 8'h20, 32'hFFFF);
    bus(1'b0, OFS_CH0_CTRL, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    // allowed and refused combinations of source, detection, bus mode and size
    for (int i = 0; i < 10; i++)
    begin
      bus(1'b1, OFS_CH0_CTRL, {21'h0, cfg[i]});
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rd & 32'h4, {29'h0, errs[i], 2'h0});
    end
    // two auto units on ch0, ordinary then sdram space, ack on read then write cycles
    // control goes in first, so the old setting never starts a unit
    for (int k = 0; k < 4; k++)
    begin
      am = k[0]; // both ack phase settings; the model unit is always read then write
      sd <= k[1];
      bad = 0;
      nack = 0;
      nhi = 0;
      bus(1'b1, OFS_CH0_CTRL, {21'h0, k[1], k[0], 9'h001});
      bus(1'b1, OFS_CH0_CNT, 32'h2);
      wait_st(4);
      check(bad, 0);
      check(nack, 2);
      check(nhi, k[1] ? 4 : 2);
      bus(1'b0, OFS_CH0_CNT, 32'h0);
      check(rd, 32'h0);
    end
    sd <= 1'b0;
    // rising-edge external request on ch1 and its start latency
    bus(1'b1, OFS_CH1_CNT, 32'h1);
    bus(1'b1, OFS_CH1_CTRL, 32'h01B);
    transfer_req_in <= 2'h2;
    lat = 0;
    while (dma_cyc_req !== 1'b1 && lat < 50)
    begin
      @(posedge hclk);
      lat++;
    end
    check(lat >= 4 && lat < 50, 1);
    wait_st(5);
    check(rd[5], 1);
    transfer_req_in <= 2'h0;
    // ch1 burst of three, ch0 cycle-steal of two joins in and alternates
    bus(1'b1, OFS_CH1_CNT, 32'h3);
    bus(1'b1, OFS_CH0_CNT, 32'h2);
    pair = 0;
    n0 = 0;
    bus(1'b1, OFS_CH1_CTRL, 32'h021);
    bus(1'b1, OFS_CH0_CTRL, 32'h001);
    wait_st(4);
    check(rd[5], 0);
    // sampled mid-cycle, away from the edge that launches it
    @(negedge hclk);
    check(dma_bus_hold, 1);
    @(posedge hclk);
    wait_st(5);
    @(negedge hclk);
    check(dma_bus_hold, 0);
    @(posedge hclk);
    check(pair, 0);
    check(n0, 2);
    // both channels in burst: ch0 breaks in and runs to its end before ch1 goes on
    bus(1'b1, OFS_CH0_CTRL, 32'h021);
    bus(1'b1, OFS_CH1_CTRL, 32'h021);
    pair = 0;
    n0 = 0;
    bus(1'b1, OFS_CH1_CNT, 32'h3);
    bus(1'b1, OFS_CH0_CNT, 32'h2);
    wait_st(4);
    check(rd[5], 0);
    wait_st(5);
    check(pair, 1);
    check(n0, 2);
    end_sim;
  end
endmodule : tb_drac_ctrl
